// ---- design/sensor_i2c_pkg.sv ----
// Shared constants and state types for the two-wire sensor register port.
// Notes on behaviour
// - Answer only target address 0x39, 7-bit.
// - Work at standard and fast clock rates.
// - Keep an 8-bit register pointer.
// - Pointer increments after every data byte.
// - Pointer survives STOP and bus release.
// - Write: address, register byte, data bytes, STOP.
// - Target acknowledges on ninth clock of address and write bytes.
// - Controller may STOP after target NACK.
// - Full read: register byte, repeated START, read.
// - Controller acknowledges all but last read byte.
// - Controller NACKs last byte; target releases data.
// - Short read continues from retained pointer.
// - After read pointer is last plus one.
// - Commands accepted only 1.5 ms after reset.
package sensor_i2c_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h39;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam int CLK_NS = 100;
    localparam int T_ACTIVE_US = 1500;
    localparam int T_ACTIVE_CYC = (T_ACTIVE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int ACT_W = 16;
    localparam int QTR_STD_NS = 2500;
    localparam int QTR_FAST_NS = 625;
    localparam logic [4:0] QTR_STD_CYC = 5'((QTR_STD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0] QTR_FAST_CYC = 5'((QTR_FAST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] ACK_BIT = 4'h8;

    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_ADDR = 3'b001,
        D_ACK_ADDR = 3'b011,
        D_WR = 3'b010,
        D_ACK_WR = 3'b110,
        D_RD = 3'b111,
        D_ACK_RD = 3'b101
    } dev_state_e;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_WRITE = 2'b01,
        M_ADDR = 2'b11,
        M_CAPT = 2'b10
    } fetch_state_e;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_SEND = 3'b011,
        H_RECV = 3'b010,
        H_STOP = 3'b110
    } host_state_e;

    typedef enum logic [2:0] {
        S_ADDRW = 3'h0,
        S_REG = 3'h1,
        S_DATAW = 3'h2,
        S_ADDRR = 3'h3
    } host_step_e;
endpackage : sensor_i2c_pkg

// ---- design/sensor_i2c_if.sv ----
// Two-wire link between controller and target, with the open-drain data wire resolved.
`timescale 1ns/1ps
interface sensor_i2c_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic sda;

    // The wire is pulled high unless either end drives a low.
    assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

    modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface : sensor_i2c_if

// ---- design/sensor_i2c_target.sv ----
// Target end: bus logic on the link clock, register access on the logic clock.
`timescale 1ns/1ps
module sensor_i2c_target
    import sensor_i2c_pkg::*;
#(
    parameter int unsigned T_ACTIVE_CYCLES = T_ACTIVE_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Link
    sensor_i2c_if.dev link,
    // Register access
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    input wire logic [7:0] reg_rdata_in,
    output logic ready_out
);
    logic [ACT_W-1:0] act_cnt_q;
    logic ready_q;
    logic rdy_m_q;
    logic rdy_s_q;
    logic start_tg_q;
    logic start_seen_q;
    dev_state_e st_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic ack_q;
    logic rd_dir_q;
    logic [7:0] ptr_q;
    logic first_q;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic wr_flag_q;
    logic evt_tg_q;
    logic drive_q;
    logic [7:0] tx_q;
    logic evt_m1_q;
    logic evt_m2_q;
    logic evt_m3_q;
    fetch_state_e mst_q;
    logic [7:0] hold_q;
    logic start_now;
    logic byte_done;
    logic [7:0] rx_byte;

    // Power-up delay before the port answers its address.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            act_cnt_q <= '0;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            if (act_cnt_q == ACT_W'(T_ACTIVE_CYCLES - 1)) begin
                ready_q <= 1'b1;
            end
            act_cnt_q <= act_cnt_q + ACT_W'(1);
        end
    end

    assign ready_out = ready_q;

    // The ready level crosses into the link domain through two flip-flops.
    always_ff @(posedge link.scl or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdy_m_q <= 1'b0;
            rdy_s_q <= 1'b0;
        end else begin
            rdy_m_q <= ready_q;
            rdy_s_q <= rdy_m_q;
        end
    end

    // A falling data line while the clock is high marks a START.
    always_ff @(negedge link.sda or negedge reset_n_in) begin
        if (!reset_n_in) begin
            start_tg_q <= 1'b0;
        end else if (link.scl) begin
            start_tg_q <= ~start_tg_q;
        end
    end

    assign start_now = start_tg_q != start_seen_q;
    assign byte_done = bit_q == 3'h7;
    assign rx_byte = {sh_q[6:0], link.sda};

    // Bit and byte sequencing, sampled on the rising link clock.
    always_ff @(posedge link.scl or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= D_IDLE;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            ack_q <= 1'b0;
            rd_dir_q <= 1'b0;
            start_seen_q <= 1'b0;
        end else begin
            start_seen_q <= start_tg_q;
            if (start_now) begin
                st_q <= D_ADDR;
                bit_q <= 3'h1;
                sh_q <= {7'h00, link.sda};
            end else begin
                case (st_q)
                    D_ADDR: begin
                        sh_q <= rx_byte;
                        bit_q <= bit_q + 3'h1;
                        if (byte_done) begin
                            st_q <= D_ACK_ADDR;
                            ack_q <= (rx_byte[7:1] == TARGET_ADDR) && rdy_s_q;
                            rd_dir_q <= rx_byte[0] == DIR_READ;
                        end
                    end
                    D_ACK_ADDR: begin
                        bit_q <= 3'h0;
                        if (!ack_q) begin
                            st_q <= D_IDLE;
                        end else if (rd_dir_q) begin
                            st_q <= D_RD;
                        end else begin
                            st_q <= D_WR;
                        end
                    end
                    D_WR: begin
                        sh_q <= rx_byte;
                        bit_q <= bit_q + 3'h1;
                        if (byte_done) begin
                            st_q <= D_ACK_WR;
                        end
                    end
                    D_ACK_WR: begin
                        bit_q <= 3'h0;
                        st_q <= D_WR;
                    end
                    D_RD: begin
                        bit_q <= bit_q + 3'h1;
                        if (byte_done) begin
                            st_q <= D_ACK_RD;
                        end
                    end
                    D_ACK_RD: begin
                        bit_q <= 3'h0;
                        st_q <= link.sda ? D_IDLE : D_RD;
                    end
                    default: begin
                        st_q <= D_IDLE;
                    end
                endcase
            end
        end
    end

    // Register pointer and the events that hand words to the logic clock.
    always_ff @(posedge link.scl or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ptr_q <= PTR_RESET;
            first_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            wr_flag_q <= 1'b0;
            evt_tg_q <= 1'b0;
        end else if (!start_now) begin
            if (st_q == D_ACK_ADDR) begin
                first_q <= 1'b1;
            end else if (st_q == D_WR && byte_done) begin
                evt_tg_q <= ~evt_tg_q;
                if (first_q) begin
                    first_q <= 1'b0;
                    ptr_q <= rx_byte;
                    wr_flag_q <= 1'b0;
                end else begin
                    wr_addr_q <= ptr_q;
                    wr_data_q <= rx_byte;
                    ptr_q <= ptr_q + 8'h01;
                    wr_flag_q <= 1'b1;
                end
            end else if (st_q == D_ACK_RD) begin
                ptr_q <= ptr_q + 8'h01;
                wr_flag_q <= 1'b0;
                evt_tg_q <= ~evt_tg_q;
            end
        end
    end

    // Data line is changed only while the link clock is low.
    always_ff @(negedge link.scl or negedge reset_n_in) begin
        if (!reset_n_in) begin
            drive_q <= 1'b0;
            tx_q <= 8'h00;
        end else begin
            case (st_q)
                D_ACK_ADDR: begin
                    drive_q <= ack_q && !start_now;
                end
                D_ACK_WR: begin
                    drive_q <= !start_now;
                end
                D_RD: begin
                    if (bit_q == 3'h0) begin
                        drive_q <= !hold_q[7] && !start_now;
                        tx_q <= {hold_q[6:0], 1'b0};
                    end else begin
                        drive_q <= !tx_q[7] && !start_now;
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
                default: begin
                    drive_q <= 1'b0;
                end
            endcase
        end
    end

    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe_n = ~drive_q;

    // The pointer event toggle is synchronised before the fetch logic acts on it.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            evt_m1_q <= 1'b0;
            evt_m2_q <= 1'b0;
            evt_m3_q <= 1'b0;
        end else begin
            evt_m1_q <= evt_tg_q;
            evt_m2_q <= evt_m1_q;
            evt_m3_q <= evt_m2_q;
        end
    end

    // Performs pending writes, then fetches the byte the pointer selects.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            mst_q <= M_ADDR;
            reg_addr_out <= PTR_RESET;
            reg_wdata_out <= 8'h00;
            reg_wr_out <= 1'b0;
            hold_q <= 8'h00;
        end else begin
            reg_wr_out <= 1'b0;
            case (mst_q)
                M_IDLE: begin
                    if (evt_m2_q != evt_m3_q) begin
                        mst_q <= wr_flag_q ? M_WRITE : M_ADDR;
                    end
                end
                M_WRITE: begin
                    reg_addr_out <= wr_addr_q;
                    reg_wdata_out <= wr_data_q;
                    reg_wr_out <= 1'b1;
                    mst_q <= M_ADDR;
                end
                M_ADDR: begin
                    reg_addr_out <= ptr_q;
                    mst_q <= M_CAPT;
                end
                M_CAPT: begin
                    hold_q <= reg_rdata_in;
                    mst_q <= M_IDLE;
                end
                default: begin
                    mst_q <= M_IDLE;
                end
            endcase
        end
    end
endmodule : sensor_i2c_target

// ---- design/sensor_i2c_host.sv ----
// Controller end: derives the link clock and runs write, full read and short read.
`timescale 1ns/1ps
module sensor_i2c_host
    import sensor_i2c_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Link
    sensor_i2c_if.host link,
    // Command
    input wire logic fast_mode_in,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic cmd_read_in,
    input wire logic cmd_short_in,
    input wire logic [7:0] cmd_reg_in,
    input wire logic [7:0] cmd_count_in,
    // Data
    input wire logic [7:0] wr_data_in,
    output logic wr_take_out,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic done_out,
    output logic nack_out
);
    host_state_e st_q;
    host_step_e step_q;
    logic [4:0] div_q;
    logic [1:0] qtr_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] cnt_q;
    logic rd_q;
    logic [7:0] reg_q;
    logic nackbit_q;
    logic sda_m_q;
    logic sda_s_q;
    logic scl_q;
    logic low_q;
    logic tick;
    logic slot_end;
    logic want_data;

    assign tick = div_q == 5'h00;
    assign slot_end = tick && qtr_q == 2'h3 && st_q != H_IDLE;
    assign cmd_ready_out = st_q == H_IDLE && tick;
    assign want_data = step_q == S_REG || step_q == S_DATAW;
    assign wr_take_out = slot_end && st_q == H_SEND && bit_q == ACK_BIT && !nackbit_q
        && !rd_q && want_data && cnt_q != 8'h00;

    // Quarter-period divider; the rate follows the selected bus speed.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            div_q <= 5'h00;
            qtr_q <= 2'h0;
        end else begin
            if (tick) begin
                div_q <= (fast_mode_in ? QTR_FAST_CYC : QTR_STD_CYC) - 5'h01;
            end else begin
                div_q <= div_q - 5'h01;
            end
            if (st_q == H_IDLE) begin
                qtr_q <= 2'h0;
            end else if (tick) begin
                qtr_q <= qtr_q + 2'h1;
            end
        end
    end

    // The data wire passes two flip-flops before it is read.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            sda_m_q <= link.sda;
            sda_s_q <= sda_m_q;
        end
    end

    // Transaction sequencing, one bit slot of four quarters at a time.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            st_q <= H_IDLE;
            step_q <= S_ADDRW;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            cnt_q <= 8'h00;
            rd_q <= 1'b0;
            reg_q <= 8'h00;
            nackbit_q <= 1'b0;
            nack_out <= 1'b0;
            rd_valid_out <= 1'b0;
            rd_data_out <= 8'h00;
            done_out <= 1'b0;
        end else begin
            rd_valid_out <= 1'b0;
            done_out <= 1'b0;
            if (st_q == H_IDLE) begin
                if (cmd_valid_in && tick) begin
                    st_q <= H_START;
                    step_q <= cmd_short_in ? S_ADDRR : S_ADDRW;
                    rd_q <= cmd_read_in || cmd_short_in;
                    reg_q <= cmd_reg_in;
                    cnt_q <= cmd_count_in;
                    nack_out <= 1'b0;
                end
            end else begin
                if (tick && qtr_q == 2'h1 && st_q == H_RECV && bit_q < ACK_BIT) begin
                    sh_q <= {sh_q[6:0], sda_s_q};
                end
                if (tick && qtr_q == 2'h1 && st_q == H_SEND && bit_q == ACK_BIT) begin
                    nackbit_q <= sda_s_q;
                end
                if (slot_end) begin
                    case (st_q)
                        H_START: begin
                            st_q <= H_SEND;
                            sh_q <= {TARGET_ADDR, step_q == S_ADDRR ? DIR_READ : DIR_WRITE};
                            bit_q <= 4'h0;
                        end
                        H_SEND: begin
                            if (bit_q != ACK_BIT) begin
                                sh_q <= {sh_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                            end else if (nackbit_q) begin
                                st_q <= H_STOP;
                                nack_out <= 1'b1;
                            end else begin
                                bit_q <= 4'h0;
                                if (step_q == S_ADDRW) begin
                                    sh_q <= reg_q;
                                    step_q <= S_REG;
                                end else if (step_q == S_ADDRR) begin
                                    st_q <= H_RECV;
                                end else if (rd_q) begin
                                    st_q <= H_START;
                                    step_q <= S_ADDRR;
                                end else if (cnt_q == 8'h00) begin
                                    st_q <= H_STOP;
                                end else begin
                                    sh_q <= wr_data_in;
                                    cnt_q <= cnt_q - 8'h01;
                                    step_q <= S_DATAW;
                                end
                            end
                        end
                        H_RECV: begin
                            if (bit_q == 4'h7) begin
                                rd_data_out <= sh_q;
                                rd_valid_out <= 1'b1;
                                bit_q <= ACK_BIT;
                            end else if (bit_q == ACK_BIT) begin
                                bit_q <= 4'h0;
                                if (cnt_q <= 8'h01) begin
                                    st_q <= H_STOP;
                                    cnt_q <= 8'h00;
                                end else begin
                                    cnt_q <= cnt_q - 8'h01;
                                end
                            end else begin
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                        H_STOP: begin
                            st_q <= H_IDLE;
                            done_out <= 1'b1;
                        end
                        default: begin
                            st_q <= H_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // Registered clock and data drive for each quarter of the slot.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            scl_q <= 1'b1;
            low_q <= 1'b0;
        end else begin
            case (st_q)
                H_START: begin
                    scl_q <= qtr_q == 2'h1 || qtr_q == 2'h2 || (qtr_q == 2'h0 && scl_q);
                    low_q <= qtr_q[1];
                end
                H_SEND: begin
                    scl_q <= qtr_q == 2'h1 || qtr_q == 2'h2;
                    low_q <= bit_q != ACK_BIT && !sh_q[7];
                end
                H_RECV: begin
                    scl_q <= qtr_q == 2'h1 || qtr_q == 2'h2;
                    low_q <= bit_q == ACK_BIT && cnt_q > 8'h01;
                end
                H_STOP: begin
                    scl_q <= qtr_q != 2'h0;
                    low_q <= !qtr_q[1];
                end
                default: begin
                    scl_q <= 1'b1;
                    low_q <= 1'b0;
                end
            endcase
        end
    end

    assign link.scl = scl_q;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe_n = ~low_q;
endmodule : sensor_i2c_host

// ---- tb/sensor_i2c_checker.sv ----
// Checker for the two-wire link between the controller and target ends.
`timescale 1ns/1ps
module sensor_i2c_checker
    import sensor_i2c_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Link
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    // Target status
    input wire logic ready_in
);
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt_q;
    logic [7:0] sr_q;
    logic rdy_go_q;
    wire start_w = scl & scl_q & sda_q & ~sda;
    wire stop_w = scl & scl_q & ~sda_q & sda;
    wire rise_w = scl & ~scl_q;

    always_ff @(posedge mclk_in) begin
        scl_q <= scl;
        sda_q <= sda;
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in || start_w) begin
            cnt_q <= 4'h0;
        end else if (rise_w && cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rise_w && cnt_q < 4'h8) begin
            sr_q <= {sr_q[6:0], sda};
        end
    end

    // Remembers whether the target was ready when the frame began.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            rdy_go_q <= 1'b0;
        end else if (start_w) begin
            rdy_go_q <= ready_in;
        end
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    AST_DEV_HOLD: assert property (scl && scl_q |-> $stable(dev_sda_oe_n))
        else $error("target changed sda while scl high");
    AST_OPEN_DRAIN: assert property (!host_sda_o && !dev_sda_o)
        else $error("data driven high by an end");
    AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high phase too short");
    AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*8])
        else $error("scl low phase too short");
    AST_FRAME_BY_HOST: assert property (scl && scl_q && sda != sda_q |-> $changed(host_sda_oe_n))
        else $error("framing edge not made by controller");
    AST_STOP_RELEASE: assert property (stop_w |-> dev_sda_oe_n [*8])
        else $error("target drives data after stop");
    AST_START_CLOCKS: assert property (start_w |-> ##[1:60] !scl)
        else $error("no clocking after start");
    AST_ADDR_ACK: assert property (rise_w && cnt_q == 4'h8 && rdy_go_q |->
        sda == (sr_q[7:1] != TARGET_ADDR))
        else $error("wrong answer to target address");
    AST_EARLY_NACK: assert property (rise_w && cnt_q == 4'h8 && !ready_in |-> sda)
        else $error("address answered before ready");

    COV_START: cover property (start_w);
    COV_RESTART: cover property (stop_w ##[1:200] start_w);
    COV_ACK: cover property (rise_w && cnt_q == 4'h8 && !sda);
    COV_NACK: cover property (rise_w && cnt_q == 4'h8 && sda);
endmodule : sensor_i2c_checker

// ---- tb/sensor_i2c_register_port_tb.sv ----
// Testbench joining the controller and target ends through the two-wire link.
`timescale 1ns/1ps
module sensor_i2c_register_port_tb;
    import sensor_i2c_pkg::*;
    localparam int ACT = 400;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b1;
    logic fast_mode_in = 1'b1;
    logic cmd_valid_in = 1'b0;
    logic cmd_read_in = 1'b0;
    logic cmd_short_in = 1'b0;
    logic [7:0] cmd_reg_in = 8'h00;
    logic [7:0] cmd_count_in = 8'h00;
    logic [7:0] wr_data_in = 8'h00;
    logic cmd_ready_out, wr_take_out, rd_valid_out, done_out, nack_out;
    logic reg_wr_out, ready_out;
    logic [7:0] rd_data_out, reg_addr_out, reg_wdata_out;
    logic [7:0] regs [0:255];
    logic [7:0] dbuf [0:7];
    logic [7:0] rbuf [0:7];
    int wk = 0;
    int rk = 0;
    int cyc = 0;
    int fails = 0;
    int samples_checked = 0;

    sensor_i2c_if link ();
    sensor_i2c_host i_sensor_i2c_host (.mclk_in, .reset_n_in, .link, .fast_mode_in,
        .cmd_valid_in, .cmd_ready_out, .cmd_read_in, .cmd_short_in, .cmd_reg_in,
        .cmd_count_in, .wr_data_in, .wr_take_out, .rd_data_out, .rd_valid_out,
        .done_out, .nack_out);
    sensor_i2c_target #(.T_ACTIVE_CYCLES(ACT)) i_sensor_i2c_target (.mclk_in, .reset_n_in,
        .link, .reg_addr_out, .reg_wdata_out, .reg_wr_out,
        .reg_rdata_in(regs[reg_addr_out]), .ready_out);
    sensor_i2c_checker i_sensor_i2c_checker (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .scl(link.scl), .sda(link.sda), .host_sda_o(link.host_sda_o),
        .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe_n(link.dev_sda_oe_n), .ready_in(ready_out));

    always #50 mclk_in = ~mclk_in;

    // Register file behind the target.
    always @(posedge mclk_in) begin
        if (reg_wr_out === 1'b1) regs[reg_addr_out] <= reg_wdata_out;
    end

    // Write data feed and read data capture.
    always @(posedge mclk_in) begin
        if (wr_take_out === 1'b1) begin
            wk <= wk + 1;
            wr_data_in <= dbuf[3'(wk + 1)];
        end
    end

    always @(negedge mclk_in) begin
        if (rd_valid_out === 1'b1) begin
            rbuf[3'(rk)] <= rd_data_out;
            rk <= rk + 1;
        end
    end

    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            finish_test();
        end
    end

    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task finish_test;
        $display("Comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test

    task automatic xfer(input logic fm, input logic rd, input logic sh, input logic [7:0] ra,
        input logic [7:0] n);
        @(posedge mclk_in);
        fast_mode_in <= fm;
        cmd_read_in <= rd;
        cmd_short_in <= sh;
        cmd_reg_in <= ra;
        cmd_count_in <= n;
        wr_data_in <= dbuf[0];
        wk <= 0;
        rk <= 0;
        cmd_valid_in <= 1'b1;
        do @(negedge mclk_in); while (cmd_ready_out !== 1'b1);
        @(posedge mclk_in);
        cmd_valid_in <= 1'b0;
        do @(negedge mclk_in); while (done_out !== 1'b1);
    endtask : xfer

    task automatic rdchk(input logic [7:0] a, input int n);
        check("rd_count", 8'(rk), 8'(n));
        for (int i = 0; i < n; i++) check("rd_data", rbuf[i], regs[8'(a + 8'(i))]);
    endtask : rdchk

    initial begin
        // A falling reset edge also clears the link-side flip-flops.
        reset_n_in <= 1'b0;
        for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5a;
        for (int i = 0; i < 8; i++) dbuf[i] = 8'h30 + 8'(i);
        repeat (6) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        repeat (10) @(negedge mclk_in);
        check("ready_early", {7'h00, ready_out}, 8'h00);
        xfer(1'b1, 1'b0, 1'b0, 8'h20, 8'h01);
        check("nack_early", {7'h00, nack_out}, 8'h01);
        check("no_write", regs[8'h20], 8'h7a);
        $display("Test early nack done");
        repeat (ACT) @(negedge mclk_in);
        check("ready_late", {7'h00, ready_out}, 8'h01);
        $display("Test ready done");
        xfer(1'b0, 1'b0, 1'b0, 8'hfe, 8'h03);
        check("nack", {7'h00, nack_out}, 8'h00);
        for (int i = 0; i < 3; i++) check("wr", regs[8'hfe + 8'(i)], 8'h30 + 8'(i));
        $display("Test standard write done");
        xfer(1'b1, 1'b1, 1'b0, 8'hfd, 8'h04);
        rdchk(8'hfd, 4);
        $display("Test full read done");
        xfer(1'b1, 1'b0, 1'b1, 8'h00, 8'h03);
        rdchk(8'h01, 3);
        $display("Test short read done");
        xfer(1'b1, 1'b0, 1'b0, 8'h40, 8'h00);
        xfer(1'b1, 1'b0, 1'b1, 8'h00, 8'h02);
        rdchk(8'h40, 2);
        $display("Test pointer set done");
        xfer(1'b1, 1'b0, 1'b0, 8'h10, 8'h01);
        check("wr_one", regs[8'h10], 8'h30);
        xfer(1'b1, 1'b0, 1'b1, 8'h00, 8'h01);
        rdchk(8'h11, 1);
        $display("Test write increment done");
        finish_test();
    end
endmodule : sensor_i2c_register_port_tb
